// ===== hdl/dbar_consts.svh
// Register offsets, field positions and reset values of the daisy bridge address bank
`ifndef DBAR_CONSTS_SVH
`define DBAR_CONSTS_SVH
`define DBAR_NORTH_ADDR_OFS    12'h306
`define DBAR_SOUTH_ADDR_OFS    12'h307
`define DBAR_PRIMARY_CTRL_OFS  12'h309
`define DBAR_EVENT_STAT_OFS    12'h30C
`define DBAR_ADDR_RESET        8'h00
`define DBAR_CTRL_RESET        8'h00
`define DBAR_ADDR_MASK         8'h3F
`define DBAR_BIT_DIR_SEL       7
`define DBAR_BIT_TONE_A        6
`define DBAR_BIT_WAKE          5
`define DBAR_BIT_SLP_TO_ACT    4
`define DBAR_BIT_SHUTDOWN      3
`define DBAR_BIT_SLEEP         2
`define DBAR_BIT_SOFT_RESET    1
`define DBAR_BIT_AUTO_ADDR     0
`define DBAR_SELF_CLEAR_MASK   8'h7F
`define DBAR_UNMAPPED_DATA     32'h00000000
`endif

// ===== hdl/dbar_pkg.sv
// Types shared by the daisy bridge address bank
`default_nettype none
package dbar_pkg;
  typedef logic [5:0] dbar_addr_t;
  typedef logic [7:0] dbar_byte_t;
  typedef enum logic [1:0] {
    DBAR_IDLE,
    DBAR_ANSWER
  } dbar_bus_state_t;
endpackage : dbar_pkg
`default_nettype wire

// ===== hdl/dbar_pulse_gen.sv
// Command pulse for one control bit: set_pulse registered one cycle later
`timescale 1ns/10ps
`default_nettype none
module dbar_pulse_gen (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Command
  input  wire logic set_pulse,
  // Pulse out
  output logic      pulse_out
);
  logic pulse_reg;
  logic pulse_next;

  always_comb begin
    pulse_next = set_pulse;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  assign pulse_out = pulse_reg;
endmodule : dbar_pulse_gen
`default_nettype wire

// ===== hdl/dbar_regs.sv
// Daisy bridge address bank with Avalon-MM slave
`timescale 1ns/10ps
`default_nettype none
`include "dbar_consts.svh"

//
// Contract
// RULE_01 - With direction select 0 the north address is the active address and reads back as stored.
// RULE_02 - With direction select 1 the south address is the active address and reads back as stored.
// RULE_03 - Both direction address registers are 0x00 after reset.
// RULE_04 - A written address takes effect at once with no further command.
// RULE_05 - The control register holds eight read-write bits reset to 0 in the documented order; only bit 7 holds, bits 6 to 0 self-clear.
// RULE_06 - Setting auto-address arm starts addressing, drops the first transaction, and clears itself.
// RULE_07 - Writing 1 to soft reset restores defaults and the bit clears itself.
// RULE_08 - Bit 7 of each address register reads 0 and never affects the active address.
module dbar_regs
  import dbar_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Forwarding logic
  input  wire logic        frame_received,
  output logic             frame_suppress,
  output logic             addressing_active,
  output logic      [5:0]  active_address,
  output logic             direction_select,
  // Command strobes
  output logic             tone_a,
  output logic             wake_tone,
  output logic             send_sleep_to_active_tone,
  output logic             enter_shutdown,
  output logic             enter_sleep,
  output logic             soft_reset_pulse
);

  function automatic logic [7:0] dbar_read_mux(input logic [11:0] a, input dbar_addr_t n,
                                               input dbar_addr_t s, input dbar_byte_t c,
                                               input logic aa);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `DBAR_NORTH_ADDR_OFS:   r = {2'b00, n}; // RULE_08
      `DBAR_SOUTH_ADDR_OFS:   r = {2'b00, s}; // RULE_08
      `DBAR_PRIMARY_CTRL_OFS: r = c;
      `DBAR_EVENT_STAT_OFS:   r = {7'h00, aa};
      default:                r = 8'h00;
    endcase
    return r;
  endfunction : dbar_read_mux

  dbar_bus_state_t state_reg, state_next;
  dbar_addr_t      north_reg, north_next;
  dbar_addr_t      south_reg, south_next;
  dbar_byte_t      ctrl_reg, ctrl_next;
  logic            aa_reg, aa_next;
  logic [31:0]     rdata_reg, rdata_next;
  logic            wait_reg, wait_next;
  logic [5:0]      act_reg, act_next;
  logic            sup_reg, sup_next;
  logic [7:0]      strobe_reg, strobe_next;
  logic            sr_req;
  logic            sr_pulse;
  logic            wr_lane0;

  // Write lands only on the edge that sees waitrequest low, never while the bus still waits
  assign wr_lane0 = avs_write && avs_byteenable[0] && (state_reg == DBAR_ANSWER);

  always_comb begin
    state_next  = state_reg;
    north_next  = north_reg;
    south_next  = south_reg;
    ctrl_next   = ctrl_reg & ~`DBAR_SELF_CLEAR_MASK; // RULE_06 RULE_07
    aa_next     = aa_reg;
    rdata_next  = rdata_reg;
    wait_next   = 1'b1;
    strobe_next = 8'h00;
    sup_next    = 1'b0;
    sr_req      = 1'b0;
    case (state_reg)
      DBAR_IDLE: begin
        if (avs_read || avs_write) begin
          state_next = DBAR_ANSWER;
          wait_next  = 1'b0;
          rdata_next = {24'h000000, dbar_read_mux(avs_address, north_reg, south_reg, ctrl_reg, aa_reg)};
        end
      end
      DBAR_ANSWER: begin
        state_next = DBAR_IDLE;
        rdata_next = `DBAR_UNMAPPED_DATA;
      end
      default: begin
        state_next = DBAR_IDLE;
      end
    endcase
    if (wr_lane0) begin
      case (avs_address)
        `DBAR_NORTH_ADDR_OFS:   north_next = avs_writedata[5:0]; // RULE_04 RULE_08
        `DBAR_SOUTH_ADDR_OFS:   south_next = avs_writedata[5:0]; // RULE_04 RULE_08
        `DBAR_PRIMARY_CTRL_OFS: begin
          ctrl_next   = avs_writedata[7:0]; // RULE_05
          strobe_next = avs_writedata[7:0] & `DBAR_SELF_CLEAR_MASK;
          sr_req      = avs_writedata[`DBAR_BIT_SOFT_RESET]; // RULE_07
        end
        default: begin
        end
      endcase
    end
    // Auto-address: arm, then drop first frame
    if (strobe_reg[`DBAR_BIT_AUTO_ADDR]) begin
      aa_next = 1'b1; // RULE_06
    end else if (aa_reg && frame_received) begin
      aa_next  = 1'b0;
      sup_next = 1'b1; // RULE_06
    end
    if (sr_pulse) begin
      // Soft reset wins over a same-cycle write
      north_next = 6'(`DBAR_ADDR_RESET); // RULE_07
      south_next = 6'(`DBAR_ADDR_RESET);
      ctrl_next  = `DBAR_CTRL_RESET;
      aa_next    = 1'b0;
    end
    // Active address loads on the same edge as the stored value
    act_next = ctrl_next[`DBAR_BIT_DIR_SEL] ? south_next : north_next; // RULE_01 RULE_02 RULE_04
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= DBAR_IDLE;
      north_reg  <= 6'(`DBAR_ADDR_RESET); // RULE_03
      south_reg  <= 6'(`DBAR_ADDR_RESET); // RULE_03
      ctrl_reg   <= `DBAR_CTRL_RESET; // RULE_05
      aa_reg     <= 1'b0;
      rdata_reg  <= 32'h00000000;
      wait_reg   <= 1'b1;
      act_reg    <= 6'h00;
      sup_reg    <= 1'b0;
      strobe_reg <= 8'h00;
    end else begin
      state_reg  <= state_next;
      north_reg  <= north_next;
      south_reg  <= south_next;
      ctrl_reg   <= ctrl_next;
      aa_reg     <= aa_next;
      rdata_reg  <= rdata_next;
      wait_reg   <= wait_next;
      act_reg    <= act_next;
      sup_reg    <= sup_next;
      strobe_reg <= strobe_next;
    end
  end

  dbar_pulse_gen u_soft_reset (
    .clk       (clk),
    .rst_n     (rst_n),
    .set_pulse (sr_req),
    .pulse_out (sr_pulse)
  );

  assign avs_readdata              = rdata_reg;
  assign avs_waitrequest           = wait_reg;
  assign active_address            = act_reg;
  assign direction_select          = ctrl_reg[`DBAR_BIT_DIR_SEL];
  assign addressing_active         = aa_reg;
  assign frame_suppress            = sup_reg;
  assign tone_a                    = strobe_reg[`DBAR_BIT_TONE_A];
  assign wake_tone                 = strobe_reg[`DBAR_BIT_WAKE];
  assign send_sleep_to_active_tone = strobe_reg[`DBAR_BIT_SLP_TO_ACT];
  assign enter_shutdown            = strobe_reg[`DBAR_BIT_SHUTDOWN];
  assign enter_sleep               = strobe_reg[`DBAR_BIT_SLEEP];
  assign soft_reset_pulse          = strobe_reg[`DBAR_BIT_SOFT_RESET];

  north_active_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
    !ctrl_reg[7] |-> act_reg == north_reg)
    else $error("active address not north");
  south_active_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
    ctrl_reg[7] |-> act_reg == south_reg)
    else $error("active address not south");
  addr_reset_a: assert property (@(posedge clk) $rose(rst_n) |-> north_reg == 6'h00 && south_reg == 6'h00) // RULE_03
    else $error("address not zero after reset");
  write_adopt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    wr_lane0 && avs_address == 12'h306 && !sr_pulse |=> north_reg == $past(avs_writedata[5:0]))
    else $error("north write not adopted");
  ctrl_selfclr_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    !wr_lane0 |=> (ctrl_reg & 8'h7F) == 8'h00)
    else $error("control bits did not self clear");
  arm_start_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    strobe_reg[0] && !sr_pulse |=> aa_reg)
    else $error("auto address not armed");
  first_drop_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_06
    aa_reg && !strobe_reg[0] && frame_received && !sr_pulse |=> frame_suppress && !aa_reg)
    else $error("first frame not dropped");
  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    wr_lane0 && avs_address == 12'h309 && avs_writedata[1] |-> ##2 north_reg == 6'h00 && ctrl_reg == 8'h00)
    else $error("soft reset did not restore defaults");
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    $past(avs_read) && !wait_reg && $past(avs_address) == 12'h306 |-> avs_readdata[7:6] == 2'b00)
    else $error("reserved bit read nonzero");
  south_adopt_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    wr_lane0 && avs_address == 12'h307 && !sr_pulse |=> south_reg == $past(avs_writedata[5:0]))
    else $error("south write not adopted");
  write_edge_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
    wr_lane0 |-> !avs_waitrequest)
    else $error("write taken while waitrequest high");
  strobe_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
    wr_lane0 && avs_address == 12'h309 |=> strobe_reg == ($past(avs_writedata[7:0]) & 8'h7F))
    else $error("command strobes wrong");
  soft_once_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
    sr_pulse |=> !sr_pulse)
    else $error("soft reset pulse longer than one cycle");
  reserved_south_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
    $past(avs_read) && !wait_reg && $past(avs_address) == 12'h307 |-> avs_readdata[7:6] == 2'b00)
    else $error("reserved south bit read nonzero");
endmodule : dbar_regs
`default_nettype wire

// ===== bench/dbar_frame_src.sv
// Frame source standing in for the forwarding logic
`timescale 1ns/10ps
`default_nettype none
module dbar_frame_src (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench request
  input  wire logic send,
  // Link to the bank
  output logic      frame_received,
  input  wire logic frame_suppress,
  output var int    dropped
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_received <= 1'b0;
      dropped        <= 0;
    end else begin
      frame_received <= send;
      if (frame_suppress) dropped <= dropped + 1;
    end
  end
endmodule : dbar_frame_src
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the daisy bridge address bank
`timescale 1ns/10ps
`default_nettype none
`include "dbar_consts.svh"
module tb;
  import dbar_pkg::*;
  logic        clk, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, send = 1'b0, clr = 1'b0;
  logic [11:0] avs_address = 12'h000, a;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic [3:0]  avs_byteenable = 4'hF;
  logic        avs_waitrequest, frame_received, frame_suppress, addressing_active, direction_select;
  logic [5:0]  active_address, strb, seen;
  int          errors, compares, cyc, dropped, north, south, dir;
  dbar_regs dut_u (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frame_received(frame_received),
    .frame_suppress(frame_suppress), .addressing_active(addressing_active),
    .active_address(active_address), .direction_select(direction_select), .tone_a(strb[5]),
    .wake_tone(strb[4]), .send_sleep_to_active_tone(strb[3]), .enter_shutdown(strb[2]),
    .enter_sleep(strb[1]), .soft_reset_pulse(strb[0]));
  dbar_frame_src part_u (.clk(clk), .rst_n(rst_n), .send(send), .frame_received(frame_received),
    .frame_suppress(frame_suppress), .dropped(dropped));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Sticky record of command pulses, cleared on request
  always @(posedge clk) begin
    seen <= clr ? 6'h00 : (seen | strb);
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // One Avalon transfer; hold until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic pulse_clear();
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
  endtask : pulse_clear
  initial begin
    void'($urandom(15));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, (i == 3) ? `DBAR_PRIMARY_CTRL_OFS : 12'h306 + i[11:0], 32'h0);
      chk("reset value", 32'h0, q);
    end
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = i[0] ? `DBAR_SOUTH_ADDR_OFS : `DBAR_NORTH_ADDR_OFS;
      bus(1'b1, a, $urandom);
      if (i[0]) south = avs_writedata & 8'h3F;
      else north = avs_writedata & 8'h3F;
      chk("active_address", dir ? south : north, active_address);
      bus(1'b0, a, 32'h0);
      chk("address readback", i[0] ? south : north, q);
      if (i == 3) begin
        bus(1'b1, `DBAR_PRIMARY_CTRL_OFS, 32'h80);
        dir = 1;
        chk("direction_select", 1, direction_select);
        chk("active_address", south, active_address);
      end
    end
    $display("test addresses done");
    for (int b = 6; b >= 2; b--) begin
      pulse_clear();
      bus(1'b1, `DBAR_PRIMARY_CTRL_OFS, (1 << b) | (dir << 7));
      repeat (2) @(posedge clk);
      chk("command pulses", 1 << (b - 1), seen);
      bus(1'b0, `DBAR_PRIMARY_CTRL_OFS, 32'h0);
      chk("control readback", dir << 7, q);
    end
    $display("test commands done");
    bus(1'b1, `DBAR_PRIMARY_CTRL_OFS, (dir << 7) | 1);
    bus(1'b0, `DBAR_EVENT_STAT_OFS, 32'h0);
    chk("addressing status", 1, q);
    for (int i = 0; i < 2; i++) begin
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (3) @(posedge clk);
    end
    chk("dropped frames", 1, dropped);
    chk("addressing_active", 0, addressing_active);
    $display("test auto address done");
    bus(1'b1, 12'h308, $urandom);
    bus(1'b0, 12'h308, 32'h0);
    chk("unmapped read", `DBAR_UNMAPPED_DATA, q);
    avs_byteenable <= 4'h0;
    bus(1'b1, `DBAR_NORTH_ADDR_OFS, ~north);
    avs_byteenable <= 4'hF;
    bus(1'b0, `DBAR_NORTH_ADDR_OFS, 32'h0);
    chk("masked write", north, q);
    $display("test refusals done");
    pulse_clear();
    bus(1'b1, `DBAR_PRIMARY_CTRL_OFS, 32'h82);
    repeat (3) @(posedge clk);
    chk("soft reset pulse", 1, seen);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, (i == 3) ? `DBAR_PRIMARY_CTRL_OFS : 12'h306 + i[11:0], 32'h0);
      chk("value after soft reset", 32'h0, q);
    end
    chk("active_address", 0, active_address);
    $display("test soft reset done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
